// >>> core/alss_defs.svh
// timing counts and result codes for the adapter start-up sequencer
// assumes a 100 MHz clock; counts are defaults, overridable by parameters
`ifndef ALSS_DEFS_SVH
`define ALSS_DEFS_SVH

// confirmation response result codes
`define ALSS_RES_NORMAL      2'h0
`define ALSS_RES_TYPE_MISS   2'h1
`define ALSS_RES_OBJ_MISS    2'h2
`define ALSS_RES_DISPOSAL    2'h3

// default timeouts in clock cycles (no documented figures)
`define ALSS_ADAPTER_REPLY_CYC   32'd1000
`define ALSS_REQUEST_WAIT_CYC    32'd2000
`define ALSS_INIT_ACCEPT_CYC     32'd500
`define ALSS_GENERAL_REPLY_CYC   32'd500
`define ALSS_INIT_WORK_CYC       32'd100

`endif

// >>> core/alss_pkg.sv
// types shared by the adapter start-up sequencer
// assumes alss_defs.svh for numeric constants
package alss_pkg;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ALSS_IDLE       = 4'b0000,
        ALSS_SEND_CONF  = 4'b0001,
        ALSS_WAIT_CONF  = 4'b0010,
        ALSS_STANDBY    = 4'b0011,
        ALSS_UNRECOG    = 4'b0100,
        ALSS_ACCEPT     = 4'b0101,
        ALSS_INIT_RUN   = 4'b0110,
        ALSS_SEND_DONE  = 4'b0111,
        ALSS_WAIT_DACK  = 4'b1000,
        ALSS_DISPOSING  = 4'b1001
    } alss_state_t;

endpackage : alss_pkg

// >>> core/alss_timer.sv
// down-counting timeout helper for the start-up sequencer
// assumes load and run are driven from the same clock domain
`timescale 1ns/1ps
module alss_timer #(
    parameter int WIDTH = 32
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] count,
    output logic                  expired
);
    typedef struct packed {
        logic [WIDTH-1:0] remain;
        logic             run;
    } alss_tmr_t;

    alss_tmr_t cur;
    alss_tmr_t next_cur;

    // ------------------------------------------------------------
    // count down after load; expired pulses once when remain reaches one
    // ------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        if (load) begin
            next_cur.remain = count;
            next_cur.run    = 1'b1;
        end else if (cur.run) begin
            if (cur.remain <= WIDTH'(1))
                next_cur.run = 1'b0;
            else
                next_cur.remain = cur.remain - WIDTH'(1);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            cur <= '0;
        else
            cur <= next_cur;
    end

    // one-cycle pulse; load is kept out so no loop forms through the sequencer
    assign expired = cur.run && (cur.remain <= WIDTH'(1));
endmodule : alss_timer

// >>> core/alss_seq.sv
// adapter-side start-up sequencer: interface-data confirmation and
// adapter initialization handshakes
// assumes frame coding/decoding lives outside; events arrive as one-cycle strobes
//
// Summary of operation
// - adapter sends confirmation request after power-on; empty count is zero.
// - normal or type mismatch go standby; object mismatch also discards objects as it enters standby.
// - disposal result discards all data, unrecognized within request_wait_limit.
// - no response within adapter_reply_limit resends request, ignoring frame errors.
// - second missed response discards all data and enters unrecognized.
// - keep-data request answered within init_accept_limit, with stack start-up in the same cycle.
// - discard-data request erases device objects first, then same handling.
// - finished internal initialization sends completion notification.
// - missing completion ack resends once, then waits for fresh request.
// - one outstanding request each; requests arriving before reply are dropped.
`timescale 1ns/1ps
`include "alss_defs.svh"
module alss_seq
    import alss_pkg::*;
#(
    parameter logic [31:0] ADAPTER_REPLY_CYC = `ALSS_ADAPTER_REPLY_CYC,
    parameter logic [31:0] REQUEST_WAIT_CYC  = `ALSS_REQUEST_WAIT_CYC,
    parameter logic [31:0] INIT_ACCEPT_CYC   = `ALSS_INIT_ACCEPT_CYC,
    parameter logic [31:0] GENERAL_REPLY_CYC = `ALSS_GENERAL_REPLY_CYC,
    parameter logic [31:0] INIT_WORK_CYC     = `ALSS_INIT_WORK_CYC,
    parameter int          OBJ_W             = 8
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [OBJ_W-1:0] stored_obj_count,
    input  wire logic             conf_resp_valid,
    input  wire logic [1:0]       conf_resp_result,
    input  wire logic             frame_error,
    input  wire logic             init_req_valid,
    input  wire logic             init_req_discard,
    input  wire logic             init_work_done,
    input  wire logic             done_ack_valid,
    input  wire logic             done_ack_ok,
    output logic                  conf_req_send,
    output logic [OBJ_W-1:0]      conf_req_obj_count,
    output logic                  init_resp_send,
    output logic                  init_start,
    output logic                  done_notify_send,
    output logic                  discard_objects,
    output logic                  discard_iface_data,
    output logic                  in_standby,
    output logic                  in_unrecognized,
    output logic                  init_waiting
);
    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        alss_state_t      st;
        logic             retried;
        logic [OBJ_W-1:0] obj_count;
        logic             conf_req;
        logic             init_resp;
        logic             start;
        logic             done_send;
        logic             drop_obj;
        logic             drop_if;
    } alss_seq_t;

    alss_seq_t cur;
    alss_seq_t next_cur;

    logic        tmr_load;
    logic [31:0] tmr_count;
    logic        tmr_expired;

    alss_timer #(
        .WIDTH   (32)
    ) u_timer (
        .clk     (clk),
        .reset_n (reset_n),
        .load    (tmr_load),
        .count   (tmr_count),
        .expired (tmr_expired)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_cur           = cur;
        next_cur.conf_req  = 1'b0;
        next_cur.init_resp = 1'b0;
        next_cur.start     = 1'b0;
        next_cur.done_send = 1'b0;
        next_cur.drop_obj  = 1'b0;
        next_cur.drop_if   = 1'b0;
        tmr_load           = 1'b0;
        tmr_count          = ADAPTER_REPLY_CYC;
        case (cur.st)
            ALSS_IDLE: begin
                // first cycle after power-on reset
                next_cur.st = ALSS_SEND_CONF;
            end
            ALSS_SEND_CONF: begin
                next_cur.conf_req  = 1'b1;
                next_cur.obj_count = stored_obj_count;
                tmr_load           = 1'b1;
                tmr_count          = ADAPTER_REPLY_CYC;
                next_cur.st        = ALSS_WAIT_CONF;
            end
            ALSS_WAIT_CONF: begin
                // frame errors are simply not looked at here
                if (conf_resp_valid) begin
                    tmr_load = 1'b1;
                    if (conf_resp_result == `ALSS_RES_DISPOSAL) begin
                        next_cur.drop_obj = 1'b1;
                        next_cur.drop_if  = 1'b1;
                        next_cur.st       = ALSS_UNRECOG;
                    end else begin
                        next_cur.drop_obj = (conf_resp_result == `ALSS_RES_OBJ_MISS);
                        next_cur.st       = ALSS_STANDBY;
                    end
                end else if (tmr_expired) begin
                    if (!cur.retried) begin
                        next_cur.retried = 1'b1;
                        next_cur.st      = ALSS_SEND_CONF;
                    end else begin
                        next_cur.drop_obj = 1'b1;
                        next_cur.drop_if  = 1'b1;
                        next_cur.st       = ALSS_UNRECOG;
                    end
                end
            end
            ALSS_STANDBY: begin
                // init requests count only here; elsewhere they are dropped
                if (init_req_valid) begin
                    next_cur.drop_obj = init_req_discard;
                    next_cur.st       = ALSS_ACCEPT;
                end
            end
            ALSS_ACCEPT: begin
                // erase has completed the cycle before the answer goes out
                next_cur.init_resp = 1'b1;
                next_cur.start     = 1'b1;
                tmr_load           = 1'b1;
                tmr_count          = INIT_WORK_CYC;
                next_cur.retried   = 1'b0;
                next_cur.st        = ALSS_INIT_RUN;
            end
            ALSS_INIT_RUN: begin
                if (init_work_done)
                    next_cur.st = ALSS_SEND_DONE;
            end
            ALSS_SEND_DONE: begin
                next_cur.done_send = 1'b1;
                tmr_load           = 1'b1;
                tmr_count          = GENERAL_REPLY_CYC;
                next_cur.st        = ALSS_WAIT_DACK;
            end
            ALSS_WAIT_DACK: begin
                if (done_ack_valid && done_ack_ok) begin
                    next_cur.st = ALSS_DISPOSING;
                end else if (tmr_expired) begin
                    if (!cur.retried) begin
                        next_cur.retried = 1'b1;
                        next_cur.st      = ALSS_SEND_DONE;
                    end else begin
                        next_cur.st = ALSS_STANDBY;
                    end
                end
            end
            ALSS_DISPOSING: begin
                // initialization complete; hands over to object construction
                next_cur.st = ALSS_DISPOSING;
            end
            ALSS_UNRECOG: begin
                next_cur.st = ALSS_UNRECOG;
            end
            default: begin
                next_cur.st = ALSS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            cur <= '{st: ALSS_IDLE, default: '0};
        else
            cur <= next_cur;
    end

    // ------------------------------------------------------------
    // outputs: pulses straight from flip-flops, state flags decoded from the state register
    // ------------------------------------------------------------
    assign conf_req_send      = cur.conf_req;
    assign conf_req_obj_count = cur.obj_count;
    assign init_resp_send     = cur.init_resp;
    assign init_start         = cur.start;
    assign done_notify_send   = cur.done_send;
    assign discard_objects    = cur.drop_obj;
    assign discard_iface_data = cur.drop_if;
    assign in_standby         = (cur.st == ALSS_STANDBY);
    assign in_unrecognized    = (cur.st == ALSS_UNRECOG);
    assign init_waiting       = (cur.st == ALSS_INIT_RUN);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_req_count;
        @(posedge clk) disable iff (!reset_n)
        conf_req_send |-> conf_req_obj_count == $past(stored_obj_count);
    endproperty
    a_req_count: assert property (p_req_count) else $error("wrong object count");

    property p_std_after_resp;
        @(posedge clk) disable iff (!reset_n)
        (cur.st == ALSS_WAIT_CONF && conf_resp_valid &&
         conf_resp_result != `ALSS_RES_DISPOSAL) |=> in_standby;
    endproperty
    a_std_after_resp: assert property (p_std_after_resp) else $error("no standby");

    property p_obj_drop;
        @(posedge clk) disable iff (!reset_n)
        (cur.st == ALSS_WAIT_CONF && conf_resp_valid &&
         conf_resp_result == `ALSS_RES_OBJ_MISS) |=> discard_objects;
    endproperty
    a_obj_drop: assert property (p_obj_drop) else $error("objects kept");

    property p_disposal;
        @(posedge clk) disable iff (!reset_n)
        (cur.st == ALSS_WAIT_CONF && conf_resp_valid &&
         conf_resp_result == `ALSS_RES_DISPOSAL)
        |=> discard_iface_data && discard_objects && in_unrecognized;
    endproperty
    a_disposal: assert property (p_disposal) else $error("disposal missed");

    property p_resend;
        @(posedge clk) disable iff (!reset_n)
        (cur.st == ALSS_WAIT_CONF && tmr_expired && !conf_resp_valid && !cur.retried)
        |=> ##1 conf_req_send;
    endproperty
    a_resend: assert property (p_resend) else $error("no resend");

    property p_giveup;
        @(posedge clk) disable iff (!reset_n)
        (cur.st == ALSS_WAIT_CONF && tmr_expired && !conf_resp_valid && cur.retried)
        |=> in_unrecognized && discard_iface_data;
    endproperty
    a_giveup: assert property (p_giveup) else $error("no give-up");

    property p_init_resp;
        @(posedge clk) disable iff (!reset_n)
        (in_standby && init_req_valid) |=> ##1 (init_resp_send && init_start);
    endproperty
    a_init_resp: assert property (p_init_resp) else $error("no init answer");

    property p_erase_first;
        @(posedge clk) disable iff (!reset_n)
        (in_standby && init_req_valid && init_req_discard)
        |=> discard_objects ##1 init_resp_send;
    endproperty
    a_erase_first: assert property (p_erase_first) else $error("erase order");

    property p_done_notify;
        @(posedge clk) disable iff (!reset_n)
        (init_waiting && init_work_done) |=> ##1 done_notify_send;
    endproperty
    a_done_notify: assert property (p_done_notify) else $error("no notify");

    property p_dack_give;
        @(posedge clk) disable iff (!reset_n)
        (cur.st == ALSS_WAIT_DACK && tmr_expired && cur.retried &&
         !(done_ack_valid && done_ack_ok)) |=> in_standby;
    endproperty
    a_dack_give: assert property (p_dack_give) else $error("no return to wait");
endmodule : alss_seq

// >>> verification/alss_appliance_model.sv
// appliance-side stand-in for the adapter start-up sequencer
// assumes one clock and async active-low reset shared with the sequencer
`timescale 1ns/1ps
module alss_appliance_model (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       conf_req_send,
    input  wire logic       done_notify_send,
    input  wire logic       resp_enable,
    input  wire logic [1:0] resp_result,
    input  wire logic       init_cmd,
    input  wire logic       init_cmd_discard,
    input  wire logic       ack_enable,
    input  wire logic       ack_ok,
    output logic            conf_resp_valid,
    output logic [1:0]      conf_resp_result,
    output logic            init_req_valid,
    output logic            init_req_discard,
    output logic            done_ack_valid,
    output logic            done_ack_ok
);
    // ------------------------------------------------------------
    // answer timers
    // ------------------------------------------------------------
    logic [3:0] resp_cnt;
    logic [1:0] ack_cnt;

    // qualifiers toggle while idle so no stale value can pass for an answer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {conf_resp_valid, conf_resp_result, init_req_valid} <= 4'h0;
            {init_req_discard, done_ack_valid, done_ack_ok} <= 3'h0;
            resp_cnt <= 4'h0;
            ack_cnt  <= 2'h0;
        end else begin
            conf_resp_valid  <= 1'b0;
            done_ack_valid   <= 1'b0;
            conf_resp_result <= ~conf_resp_result;
            done_ack_ok      <= ~done_ack_ok;
            init_req_valid   <= init_cmd;
            init_req_discard <= init_cmd ? init_cmd_discard : ~init_req_discard;
            // confirmation requests and completion notifications are answered, one at a time each
            if (conf_req_send && resp_enable) begin
                resp_cnt <= 4'h3;
            end else if (resp_cnt != 4'h0) begin
                resp_cnt <= resp_cnt - 4'h1;
                if (resp_cnt == 4'h1) begin
                    conf_resp_valid  <= 1'b1;
                    conf_resp_result <= resp_result;
                end
            end
            if (done_notify_send && ack_enable) begin
                ack_cnt <= 2'h2;
            end else if (ack_cnt != 2'h0) begin
                ack_cnt <= ack_cnt - 2'h1;
                if (ack_cnt == 2'h1) begin
                    done_ack_valid <= 1'b1;
                    done_ack_ok    <= ack_ok;
                end
            end
        end
    end
endmodule : alss_appliance_model

// >>> verification/alss_seq_test.sv
// self-checking bench for the adapter start-up sequencer
// assumes alss_appliance_model on the far side; adapter-reply, general-reply and init-work counts shortened to 8 cycles
`timescale 1ns/1ps
`include "alss_defs.svh"
module alss_seq_test;
    import alss_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [31:0] TO = 32'h0000_0008;
    localparam int C_REQ = 0, C_DOBJ = 1, C_DIF = 2, C_IRESP = 3, C_ISTART = 4, C_NOTE = 5;
    typedef struct {logic [1:0] res; logic [7:0] objs; logic sb; logic un; int dobj; int dif;}
        alss_row_t;
    logic       clk, reset_n, frame_error, init_work_done, resp_enable, init_cmd;
    logic       init_cmd_discard, ack_enable, ack_ok, conf_resp_valid, init_req_valid;
    logic       init_req_discard, done_ack_valid, done_ack_ok, conf_req_send, init_resp_send;
    logic       init_start, done_notify_send, discard_objects, discard_iface_data;
    logic       in_standby, in_unrecognized, init_waiting;
    logic [1:0] resp_result, conf_resp_result;
    logic [7:0] stored_obj_count, conf_req_obj_count, last_objs;
    int         cnt [6];
    int         cyc, t_req [2], n_fail, num_checks;
    alss_row_t  rows [4] = '{'{`ALSS_RES_NORMAL, 8'h00, 1'b1, 1'b0, 0, 0},
                             '{`ALSS_RES_TYPE_MISS, 8'h05, 1'b1, 1'b0, 0, 0},
                             '{`ALSS_RES_OBJ_MISS, 8'hff, 1'b1, 1'b0, 1, 0},
                             '{`ALSS_RES_DISPOSAL, 8'h01, 1'b0, 1'b1, 1, 1}};

    alss_seq #(.ADAPTER_REPLY_CYC(TO), .GENERAL_REPLY_CYC(TO), .INIT_WORK_CYC(TO))
    alss_seq_inst (.clk(clk), .reset_n(reset_n), .stored_obj_count(stored_obj_count),
        .conf_resp_valid(conf_resp_valid), .conf_resp_result(conf_resp_result),
        .frame_error(frame_error), .init_req_valid(init_req_valid),
        .init_req_discard(init_req_discard), .init_work_done(init_work_done),
        .done_ack_valid(done_ack_valid), .done_ack_ok(done_ack_ok),
        .conf_req_send(conf_req_send), .conf_req_obj_count(conf_req_obj_count),
        .init_resp_send(init_resp_send), .init_start(init_start),
        .done_notify_send(done_notify_send), .discard_objects(discard_objects),
        .discard_iface_data(discard_iface_data), .in_standby(in_standby),
        .in_unrecognized(in_unrecognized), .init_waiting(init_waiting));

    alss_appliance_model alss_appliance_model_inst (.clk(clk), .reset_n(reset_n),
        .conf_req_send(conf_req_send), .done_notify_send(done_notify_send),
        .resp_enable(resp_enable), .resp_result(resp_result), .init_cmd(init_cmd),
        .init_cmd_discard(init_cmd_discard), .ack_enable(ack_enable), .ack_ok(ack_ok),
        .conf_resp_valid(conf_resp_valid), .conf_resp_result(conf_resp_result),
        .init_req_valid(init_req_valid), .init_req_discard(init_req_discard),
        .done_ack_valid(done_ack_valid), .done_ack_ok(done_ack_ok));

    // ------------------------------------------------------------
    // clock and pulse monitors
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // pulse counters clear with reset so each scenario starts from zero
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            foreach (cnt[i]) cnt[i] = 0;
            cyc = 0;
        end else begin
            cyc = cyc + 1;
            if (conf_req_send === 1'b1) begin
                last_objs = conf_req_obj_count;
                if (cnt[C_REQ] < 2) t_req[cnt[C_REQ]] = cyc;
            end
            cnt[C_REQ]    += int'(conf_req_send === 1'b1);
            cnt[C_DOBJ]   += int'(discard_objects === 1'b1);
            cnt[C_DIF]    += int'(discard_iface_data === 1'b1);
            cnt[C_IRESP]  += int'(init_resp_send === 1'b1);
            cnt[C_ISTART] += int'(init_start === 1'b1);
            cnt[C_NOTE]   += int'(done_notify_send === 1'b1);
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // inputs always move 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask : step

    task automatic wait_cnt(input int sel, input int n);
        int k;
        k = 0;
        while (cnt[sel] < n && k < 200) begin
            step(1);
            k++;
        end
        if (cnt[sel] < n) begin
            n_fail++;
            $display("[ERR] pulse count %0d expected %0d seen %0d", sel, n, cnt[sel]);
            stop_test();
        end
    endtask : wait_cnt

    // every reset, first or mid-run, is held 10 cycles and checked inside
    task automatic do_reset();
        reset_n = 1'b0;
        step(2);
        check("outputs in reset", {conf_req_send, init_resp_send, init_start,
              done_notify_send, discard_objects, discard_iface_data, in_standby,
              in_unrecognized, init_waiting}, 0);
        step(8);
        reset_n = 1'b1;
    endtask : do_reset

    task automatic pulse_init(input logic disc);
        init_cmd         = 1'b1;
        init_cmd_discard = disc;
        step(1);
        init_cmd         = 1'b0;
    endtask : pulse_init

    // early request while confirming must be dropped, later one served
    task automatic do_init(input logic disc, input logic ack_en, input int notes);
        resp_result = `ALSS_RES_NORMAL;
        resp_enable = 1'b1;
        ack_enable  = ack_en;
        do_reset();
        wait_cnt(C_REQ, 1);
        pulse_init(disc);
        step(8);
        check("early init response", cnt[C_IRESP], 0);
        check("standby", in_standby, 1'b1);
        pulse_init(disc);
        wait_cnt(C_IRESP, 1);
        check("init start", cnt[C_ISTART], 1);
        check("init waiting", init_waiting, 1'b1);
        check("object discards", cnt[C_DOBJ], int'(disc));
        step(2);
        init_work_done = 1'b1;
        step(1);
        init_work_done = 1'b0;
        wait_cnt(C_NOTE, notes);
        step(20);
        check("notifications", cnt[C_NOTE], notes);
    endtask : do_init

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {reset_n, frame_error, init_work_done, resp_enable, init_cmd} = 5'h00;
        {init_cmd_discard, ack_enable, ack_ok, resp_result} = 5'h04;
        {stored_obj_count, n_fail, num_checks} = '0;
        for (int i = 0; i < 4; i++) begin
            resp_result      = rows[i].res;
            stored_obj_count = rows[i].objs;
            resp_enable      = 1'b1;
            do_reset();
            wait_cnt(C_REQ, 1);
            check("object count", 32'(last_objs), 32'(rows[i].objs));
            step(8);
            check("requests", cnt[C_REQ], 1);
            check("standby", in_standby, rows[i].sb);
            check("unrecognized", in_unrecognized, rows[i].un);
            check("object discards", cnt[C_DOBJ], rows[i].dobj);
            check("iface discards", cnt[C_DIF], rows[i].dif);
        end
        // silent appliance with frame errors in the wait
        resp_enable = 1'b0;
        do_reset();
        wait_cnt(C_REQ, 1);
        frame_error = 1'b1;
        step(1);
        frame_error = 1'b0;
        wait_cnt(C_REQ, 2);
        check("resend spacing", 32'(t_req[1] - t_req[0] inside {[8:10]}), 1);
        step(12);
        check("requests", cnt[C_REQ], 2);
        check("unrecognized", in_unrecognized, 1'b1);
        check("object discards", cnt[C_DOBJ], 1);
        check("iface discards", cnt[C_DIF], 1);
        do_init(1'b1, 1'b1, 1);
        // a failed completion ack counts as no answer
        ack_ok = 1'b0;
        do_init(1'b0, 1'b1, 2);
        ack_ok = 1'b1;
        do_init(1'b0, 1'b0, 2);
        pulse_init(1'b0);
        wait_cnt(C_IRESP, 2);
        check("fresh init", cnt[C_ISTART], 2);
        stop_test();
    end
endmodule : alss_seq_test
